// ### hw/jio_core.v
/*
 Decode and execute of four instructions: absolute jump, increment with
 skip on zero, plain increment and OR literal into the accumulator.
 The accumulator and zero flag live here; the jump target and the file
 write-back leave as registered outputs.
 Assumes the fetch stage presents one instruction per instruction cycle
 with instr_valid_i, supplies the file register read value for the
 addressed file combinationally, and honours flush_o by treating the
 already fetched word as an idle instruction.
 Assumes the file store takes file_wdata_o on the edge after file_we_o
 is high; a back-to-back read of that file is served from the pending
 write instead, so the store needs no bypass of its own.
 Assumes counter_upper_latch_i is stable in the cycle a jump is taken;
 only its bits 4:3 are used.
*/
`timescale 1ns/1ps
`include "jio_defines.vh"
module jio_core #(
	parameter PC_W   = 13,
	parameter DATA_W = 8,
	parameter FA_W   = 7
) (
	// Clock and reset
	input  wire              clk_i,
	input  wire              reset_i,
	// Instruction from fetch
	input  wire              instr_valid_i,
	input  wire [13:0]       instr_i,
	// Counter upper latch value
	input  wire [DATA_W-1:0] counter_upper_latch_i,
	// File register read port
	input  wire [DATA_W-1:0] file_rdata_i,
	output wire [FA_W-1:0]   file_addr_o,
	// File register write port
	output reg               file_we_o,
	output reg  [FA_W-1:0]   file_waddr_o,
	output reg  [DATA_W-1:0] file_wdata_o,
	// Program flow
	output reg               pc_load_o,
	output reg  [PC_W-1:0]   program_counter_o,
	output wire              flush_o,
	output wire              busy_o,
	// Architectural state
	output wire [DATA_W-1:0] acc_o,
	output wire              zero_flag_o,
	output wire              zero_flag_we_o
);

	// One-hot states
	localparam ST_EXEC  = 2'b01;
	localparam ST_FLUSH = 2'b10;

	// Architectural and pipeline registers
	reg  [1:0]        state_q;
	reg  [1:0]        state_d;
	reg  [DATA_W-1:0] acc_q;
	reg  [DATA_W-1:0] acc_d;
	reg               zero_q;
	reg               zero_d;
	reg               zero_we_q;
	reg               zero_we_d;

	// Discarded cycles still to run
	reg  [1:0]        flush_cnt_q;
	reg  [1:0]        flush_cnt_d;

	// Datapath and decode nets
	wire [DATA_W-1:0] file_opnd;
	wire              fwd_hit;
	wire [DATA_W-1:0] inc_sum;
	wire              inc_zero;
	wire [DATA_W-1:0] or_res;
	wire              is_jump;
	wire              is_inc_skip;
	wire              is_inc;
	wire              is_or;
	wire              exec;
	wire              dest_file;
	wire              take_flush;

	// Pending write-back forwarded to a back-to-back reader of the same file
	assign fwd_hit   = file_we_o && (file_waddr_o == file_addr_o);
	assign file_opnd = fwd_hit ? file_wdata_o : file_rdata_i;

	// Shared incrementer
	jio_incr #(
		.WIDTH   (DATA_W)
	) u_incr (
		.value_i (file_opnd),
		.sum_o   (inc_sum),
		.zero_o  (inc_zero)
	);

	// Decode
	assign exec        = instr_valid_i && (state_q == ST_EXEC);
	assign is_jump     = (instr_i[`JIO_JUMP_PFX_HI:`JIO_JUMP_PFX_LO] == `JIO_JUMP_PFX);
	assign is_inc_skip = (instr_i[`JIO_CLASS_HI:`JIO_CLASS_LO] == `JIO_CLASS_FILE)
		&& (instr_i[`JIO_OP_HI:`JIO_OP_LO] == `JIO_OP_INC_SKIP);
	assign is_inc      = (instr_i[`JIO_CLASS_HI:`JIO_CLASS_LO] == `JIO_CLASS_FILE)
		&& (instr_i[`JIO_OP_HI:`JIO_OP_LO] == `JIO_OP_INC);
	assign is_or       = (instr_i[`JIO_OR_PFX_HI:`JIO_OR_PFX_LO] == `JIO_OR_PFX);
	assign dest_file   = instr_i[`JIO_DEST_BIT];
	assign file_addr_o = instr_i[`JIO_FADDR_HI:0];
	assign or_res      = acc_q | instr_i[`JIO_LIT_HI:0];

	// Taken jump or zero skip opens the discard window
	assign take_flush  = (state_q == ST_EXEC) && (state_d == ST_FLUSH);

	// Second cycle of jump or skip: fetched word dropped
	assign flush_o        = (state_q == ST_FLUSH);
	assign busy_o         = flush_o;
	assign acc_o          = acc_q;
	assign zero_flag_o    = zero_q;
	assign zero_flag_we_o = zero_we_q;

	// Next state and execute
	always @* begin
		state_d   = ST_EXEC;
		acc_d     = acc_q;
		zero_d    = zero_q;
		zero_we_d = 1'b0;
		if (exec) begin
			if (is_jump) begin
				state_d = ST_FLUSH;
			end else if (is_inc_skip) begin
				if (!dest_file) begin
					acc_d = inc_sum;
				end
				if (inc_zero) begin
					state_d = ST_FLUSH;
				end
			end else if (is_inc) begin
				if (!dest_file) begin
					acc_d = inc_sum;
				end
				zero_d    = inc_zero;
				zero_we_d = 1'b1;
			end else if (is_or) begin
				acc_d     = or_res;
				zero_d    = (or_res == {DATA_W{1'b0}});
				zero_we_d = 1'b1;
			end
		end
	end

	// Count of discarded cycles after a jump or a taken skip
	always @* begin
		flush_cnt_d = flush_cnt_q;
		if (take_flush) begin
			flush_cnt_d = `JIO_JUMP_CYCLES - 2'h1;
		end else if (flush_cnt_q != 2'h0) begin
			flush_cnt_d = flush_cnt_q - 2'h1;
		end
	end

	// State registers
	always @(posedge clk_i) begin
		if (reset_i) begin
			state_q   <= ST_EXEC;
			acc_q     <= `JIO_ACC_RST;
			zero_q    <= 1'b0;
			zero_we_q <= 1'b0;
			flush_cnt_q <= 2'h0;
		end else begin
			case (state_q)
				ST_EXEC: begin
					state_q <= state_d;
				end
				ST_FLUSH: begin
					state_q <= (flush_cnt_q <= 2'h1) ? ST_EXEC : ST_FLUSH;
				end
				default: begin
					state_q <= ST_EXEC;
				end
			endcase
			acc_q     <= acc_d;
			zero_q    <= zero_d;
			zero_we_q <= zero_we_d;
			flush_cnt_q <= flush_cnt_d;
		end
	end

	// File write-back
	always @(posedge clk_i) begin
		if (reset_i) begin
			file_we_o    <= 1'b0;
			file_waddr_o <= {FA_W{1'b0}};
			file_wdata_o <= {DATA_W{1'b0}};
		end else begin
			file_we_o <= exec && (is_inc_skip || is_inc) && dest_file;
			if (exec && (is_inc_skip || is_inc)) begin
				file_waddr_o <= file_addr_o;
				file_wdata_o <= inc_sum;
			end
		end
	end

	// Counter load on jump
	always @(posedge clk_i) begin
		if (reset_i) begin
			pc_load_o         <= 1'b0;
			program_counter_o <= `JIO_PC_RST;
		end else begin
			pc_load_o <= exec && is_jump;
			if (exec && is_jump) begin
				program_counter_o <= {counter_upper_latch_i[`JIO_LATCH_HI:`JIO_LATCH_LO],
					instr_i[`JIO_JUMP_ADDR_HI:0]};
			end
		end
	end

endmodule // jio_core

// ### hw/jio_defines.vh
/*
 Constants for the jump / increment / OR-literal decode and execute block.
 Assumes a 14-bit instruction word and an 8-bit data path.
*/
`ifndef JIO_DEFINES_VH
`define JIO_DEFINES_VH

// Instruction fields
`define JIO_CLASS_HI        13
`define JIO_CLASS_LO        12
`define JIO_JUMP_PFX        3'h5
`define JIO_JUMP_PFX_HI     13
`define JIO_JUMP_PFX_LO     11
`define JIO_JUMP_ADDR_HI    10
`define JIO_OP_HI           11
`define JIO_OP_LO           8
`define JIO_DEST_BIT        7
`define JIO_FADDR_HI        6
`define JIO_LIT_HI          7
`define JIO_CLASS_FILE      2'h0
`define JIO_OP_INC_SKIP     4'hF
`define JIO_OP_INC          4'hA
`define JIO_OR_PFX          6'h38
`define JIO_OR_PFX_HI       13
`define JIO_OR_PFX_LO       8
// Upper latch bits that feed the counter top
`define JIO_LATCH_HI        4
`define JIO_LATCH_LO        3
// Reset values
`define JIO_ACC_RST         8'h00
`define JIO_PC_RST          13'h0000
// Cycle counts
`define JIO_JUMP_CYCLES     2'h2

`endif

// ### hw/jio_incr.v
/*
 Eight-bit incrementer with zero detect.
 Assumes purely combinational use by the decode block on the same clock.
*/
`timescale 1ns/1ps
module jio_incr #(
	parameter WIDTH = 8
) (
	// Operand
	input  wire [WIDTH-1:0] value_i,
	// Result
	output wire [WIDTH-1:0] sum_o,
	output wire             zero_o
);

	// Add one, wrap at the top
	assign sum_o  = value_i + {{(WIDTH-1){1'b0}}, 1'b1};
	assign zero_o = (sum_o == {WIDTH{1'b0}});

endmodule // jio_incr

// ### verification/jio_fetch_model.sv
/* File register model on the far side of the decode block.
   Assumes writes land on the clock edge after file_we_o is seen. */
`timescale 1ns/1ps
module jio_fetch_model (
	// Clock
	input  wire       clk_i,
	// Read port
	input  wire [6:0] file_addr_o,
	output wire [7:0] file_rdata_i,
	// Write port
	input  wire       file_we_o,
	input  wire [6:0] file_waddr_o,
	input  wire [7:0] file_wdata_o
);
	reg [7:0] mem [0:127];
	// Fixed pattern, holds 0xFF at address 3
	initial for (int i = 0; i < 128; i++) mem[i] = i[7:0] ^ 8'hFC;
	// Same-cycle read, clocked write-back
	assign file_rdata_i = mem[file_addr_o];
	always @(posedge clk_i) if (file_we_o) mem[file_waddr_o] <= file_wdata_o;
endmodule // jio_fetch_model

// ### verification/jio_core_checker.sv
/* Port assertions for the decode and execute block.
   Assumes default widths and a bind to jio_core. */
`timescale 1ns/1ps
module jio_core_checker (
	input wire        clk_i, reset_i, instr_valid_i,
	input wire [13:0] instr_i,
	input wire [7:0]  counter_upper_latch_i, file_rdata_i, file_wdata_o, acc_o,
	input wire [6:0]  file_waddr_o, file_addr_o,
	input wire [12:0] program_counter_o,
	input wire        file_we_o, pc_load_o, flush_o, zero_flag_o, zero_flag_we_o, busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Taken instruction and its kind
	wire tk  = instr_valid_i && !flush_o;
	wire jmp = tk && instr_i[13:11] == 3'h5;
	wire isk = tk && instr_i[13:8] == 6'h0F;
	wire inc = tk && instr_i[13:8] == 6'h0A;
	wire orl = tk && instr_i[13:8] == 6'h38;
	// File value seen by the increment: a write still pending wins over the store
	wire [7:0] opnd = (file_we_o && file_waddr_o == instr_i[6:0]) ? file_wdata_o : file_rdata_i;
	a_jump_target: assert property (jmp |=> pc_load_o &&
		program_counter_o == {$past(counter_upper_latch_i[4:3]), $past(instr_i[10:0])}) else $error("bad jump");
	a_jump_cycles: assert property (jmp |=> flush_o && !zero_flag_we_o ##1 !flush_o)
		else $error("bad jump timing");
	a_skip_discard: assert property (isk |=> !zero_flag_we_o &&
		flush_o == ($past(opnd) == 8'hFF)) else $error("bad skip");
	a_inc_dest: assert property (isk || inc |=> file_we_o == $past(instr_i[7]) &&
		(file_we_o ? file_wdata_o : acc_o) == $past(opnd) + 8'h01) else $error("bad sum");
	a_inc_zero: assert property (inc |=> zero_flag_we_o &&
		zero_flag_o == ($past(opnd) == 8'hFF)) else $error("bad zero");
	a_or_acc: assert property (orl |=> zero_flag_we_o &&
		acc_o == ($past(acc_o) | $past(instr_i[7:0]))) else $error("bad or");
	a_zero_value: assert property (zero_flag_we_o |->
		zero_flag_o == ((file_we_o ? file_wdata_o : acc_o) == 8'h00)) else $error("bad flag");
	a_flush_refuse: assert property (flush_o |=> !flush_o && !file_we_o && !pc_load_o)
		else $error("flushed word ran");
	a_busy_follow: assert property (busy_o == flush_o)
		else $error("busy differs from flush");
	a_read_addr: assert property (file_addr_o == instr_i[6:0])
		else $error("bad file read address");
	c_jump: cover property (jmp);
	c_skip: cover property (isk && opnd == 8'hFF);
	c_or: cover property (orl);
endmodule // jio_core_checker
bind jio_core jio_core_checker u_chk (.*);

// ### verification/jio_core_tb_top.sv
/* Self-checking bench for jio_core with random and corner words.
   Assumes one issue cycle and one check cycle per instruction. */
`timescale 1ns/1ps
`define CHK(a,b) begin checks++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module jio_core_tb_top;
	reg         clk_i = 0, reset_i = 1, instr_valid_i = 0, ez = 0, sk;
	reg  [13:0] instr_i = 0;
	reg  [7:0]  counter_upper_latch_i = 0, ea = 0, r;
	reg  [31:0] q;
	wire [7:0]  file_rdata_i, file_wdata_o, acc_o;
	wire [6:0]  file_addr_o, file_waddr_o;
	wire [12:0] program_counter_o;
	wire        file_we_o, pc_load_o, flush_o, busy_o, zero_flag_o, zero_flag_we_o;
	int         failures = 0, checks = 0;
	jio_core uut (.*);
	jio_fetch_model fm (.*);
	// Clock, 50 ns period
	initial forever #25 clk_i = ~clk_i;
	task end_of_test;
		if (failures == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Expected jump target: latch bits 4:3 above the eleven-bit immediate
	function [12:0] exp_target(input [13:0] w, input [7:0] l);
		exp_target = {l[4:3], w[10:0]};
	endfunction
	// Issue one word, check it, then after a jump or taken skip offer a word that the flush must drop
	task run(input [13:0] w, input [7:0] l);
		instr_i = w;
		instr_valid_i = 1;
		counter_upper_latch_i = l;
		r = fm.mem[w[6:0]] + 8'h01;
		sk = 0;
		@(negedge clk_i);
		if (w[13:11] == 3'h5) begin
			`CHK({pc_load_o, program_counter_o}, {1'b1, exp_target(w, l)})
			`CHK({flush_o, zero_flag_we_o}, 2'h2)
			sk = 1;
		end else if (w[13:8] == 6'h0F || w[13:8] == 6'h0A) begin
			if (!w[7]) ea = r;
			`CHK(file_we_o, w[7])
			if (w[7]) `CHK({file_waddr_o, file_wdata_o}, {w[6:0], r})
			if (w[10]) begin
				sk = (r == 8'h00);
				`CHK({flush_o, zero_flag_we_o}, {sk, 1'b0})
			end else begin
				ez = (r == 8'h00);
				`CHK(zero_flag_we_o, 1'b1)
			end
		end else if (w[13:8] == 6'h38) begin
			ea = ea | w[7:0];
			ez = (ea == 8'h00);
			`CHK(zero_flag_we_o, 1'b1)
		end else `CHK({file_we_o, pc_load_o, flush_o}, 3'h0)
		`CHK({file_addr_o, flush_o, busy_o}, {w[6:0], sk, sk})
		`CHK({acc_o, zero_flag_o}, {ea, ez})
		instr_i = ~w;
		instr_valid_i = sk;
		@(negedge clk_i);
		if (sk) `CHK({file_we_o, pc_load_o, flush_o, acc_o}, {3'h0, ea})
	endtask
	// Corner words, then random traffic
	initial begin
		q = $urandom(67);
		repeat (3) @(negedge clk_i);
		reset_i = 0;
		run(14'h0F03, 8'h00);
		run(14'h0A83, 8'h00);
		run(14'h3800, 8'h00);
		run(14'h3835, 8'h00);
		run(14'h2FFF, 8'h18);
		run(14'h2800, 8'hE7);
		repeat (400) begin
			q = $urandom;
			run(q[2:0] == 0 ? {3'h5, q[31:21]} : q[2:0] == 1 ? {6'h0F, q[31:24]} :
				q[2:0] == 2 ? {6'h0A, q[31:24]} : q[2:0] == 3 ? {6'h38, q[31:24]} : q[31:18], q[15:8]);
		end
		// Back-to-back increments of one file ride the pending write-back
		r = fm.mem[5] + 8'h02;
		instr_i = 14'h0A85;
		instr_valid_i = 1;
		repeat (2) @(negedge clk_i);
		instr_valid_i = 0;
		@(negedge clk_i);
		ez = (r == 8'h00);
		`CHK({fm.mem[5], acc_o, zero_flag_o}, {r, ea, ez})
		end_of_test;
	end
	// Watchdog, about two and a half times the expected run
	initial begin
		#100000;
		failures++;
		end_of_test;
	end
endmodule // jio_core_tb_top
